// ==== design/hvpp_port.sv ====
// parallel high-voltage programming port with memory arrays
//
// Notes on behaviour
// - ready_busy_n low while erasing or programming
// - drive data bus only while oe_n low
// - byte select one: low/high byte, page load
// - byte select two: low or extended byte
// - action code steers what a load captures
// - decode the ten command byte values
// - strobes run the last loaded command
// - leave programming mode on reset low
// - command and address kept across operations
// - erased flash and eeprom read all ones
// - erase flash, eeprom unless kept, locks
// - locks cleared only after erase completes
// - erase: load command, pulse write, await ready
// - flash programmed by pages of words
// - eeprom programmed in four-byte pages
// - page buffer programmed whole on write
// - no-operation command ends page session
// - flash read: byte select picks byte
// - fuse/lock read chosen by byte-select pair
`timescale 1ns/10ps
module hvpp_port
  import hvpp_pkg::*;
#(
  parameter int FLASH_AW  = 10,       // flash word address bits
  parameter int PAGE_W    = 4,        // word-in-page address bits
  parameter int EE_AW     = 7,        // eeprom byte address bits
  parameter int EE_PAGE_W = 2,        // byte-in-page address bits
  parameter logic [7:0] SIG0 = 8'h5A, // signature byte 0, arbitrary value
  parameter logic [7:0] SIG1 = 8'h3C, // signature byte 1, arbitrary value
  parameter logic [7:0] SIG2 = 8'h07, // signature byte 2, arbitrary value
  parameter logic [7:0] CAL0 = 8'h80  // calibration byte, arbitrary value
) (
  input  wire logic       clock,                          // 100 MHz clock
  input  wire logic       rst,                            // sync reset, high
  input  wire logic       prog_mode,                      // high voltage on reset pin
  input  wire logic       load_strobe,                    // positive load pulse
  input  wire logic       action_select_lo,               // action bit 0
  input  wire logic       action_select_hi_byte_sel_two,  // action bit 1 / select two
  input  wire logic       byte_sel_one_page_load,         // select one / page load
  input  wire logic       wr_n,                           // write strobe, low
  input  wire logic       oe_n,                           // output enable, low
  input  wire logic [7:0] data_in,                        // bus input side
  output logic      [7:0] data_out,                       // bus output side
  output logic            data_oe_n,                      // bus enable, low drives
  output logic            ready_busy_n,                   // 1 ready, 0 busy
  output logic            in_prog                         // entry latched
);
  localparam int FW = 1 << FLASH_AW;  // flash words
  localparam int EW = 1 << EE_AW;     // eeprom bytes
  localparam int PW = 1 << PAGE_W;    // words per flash page
  localparam int EP = 1 << EE_PAGE_W; // bytes per eeprom page

  typedef enum logic [1:0] {HVPP_IDLE, HVPP_ERASE, HVPP_PROG} hvpp_state_t;

  // storage arrays
  logic [15:0] flash_mem [FW];        // flash words
  logic [7:0]  ee_mem    [EW];        // eeprom bytes
  logic [15:0] fpage     [PW];        // flash page buffer
  logic [7:0]  epage     [EP];        // eeprom page buffer

  // loaded registers
  logic [7:0]  cmd_r;                 // last loaded command
  logic [7:0]  addr_lo_r;             // address low byte
  logic [7:0]  addr_hi_r;             // address high byte
  logic [7:0]  dat_lo_r;              // data low byte
  logic [7:0]  dat_hi_r;              // data high byte
  logic [7:0]  fuse_lo_r;             // low fuses
  logic [7:0]  fuse_hi_r;             // high fuses
  logic [7:0]  fuse_ext_r;            // extended fuses
  logic [7:0]  lock_r;                // lock bits
  logic        in_prog_r;             // programming mode latched
  logic        ls_d_r;                // load strobe delayed
  logic        wr_d_r;                // write strobe delayed
  logic        pl_d_r;                // page load delayed
  logic        page_live_r;           // page buffer session open
  logic [7:0]  rd_r;                  // read data register
  logic        rd_oe_n_r;             // bus enable register
  hvpp_state_t st_r;                  // operation state
  hvpp_state_t st_nxt;                // next operation state
  logic [7:0]  wr_cmd_r;              // command running

  // decode wires
  wire [1:0] act     = {action_select_hi_byte_sel_two, action_select_lo};
  wire       bs1     = byte_sel_one_page_load;
  wire       bs2     = action_select_hi_byte_sel_two;
  wire       ls_rise = load_strobe & ~ls_d_r & in_prog_r;
  wire       wr_fall = ~wr_n & wr_d_r & in_prog_r & (st_r == HVPP_IDLE);
  wire       pl_rise = bs1 & ~pl_d_r & in_prog_r;
  wire [15:0] addr   = {addr_hi_r, addr_lo_r};
  wire [FLASH_AW-1:0] faddr = addr[FLASH_AW-1:0];
  wire [EE_AW-1:0]    eaddr = addr[EE_AW-1:0];
  wire [PAGE_W-1:0]   word_in_page_bits = faddr[PAGE_W-1:0];
  wire [FLASH_AW-PAGE_W-1:0] page_index_bits = faddr[FLASH_AW-1:PAGE_W];
  wire [EE_PAGE_W-1:0] ee_word = eaddr[EE_PAGE_W-1:0];
  wire       eeprom_keep_fuse = ~fuse_hi_r[HVPP_KEEP_BIT];  // programmed = 0
  wire       is_read = (cmd_r == HVPP_CMD_RD_SIG) | (cmd_r == HVPP_CMD_RD_FUSE)
                     | (cmd_r == HVPP_CMD_RD_FLASH) | (cmd_r == HVPP_CMD_RD_EEPROM);
  wire       timer_busy;              // self-timed op running
  wire       timer_done;              // self-timed op end pulse
  wire [7:0] op_cycles = (cmd_r == HVPP_CMD_ERASE) ? 8'(HVPP_ERASE_CYC)
                       : ((cmd_r == HVPP_CMD_WR_FUSE) | (cmd_r == HVPP_CMD_WR_LOCK))
                         ? 8'(HVPP_FUSE_CYC) : 8'(HVPP_PROG_CYC);
  wire       op_start = wr_fall & (cmd_r != HVPP_CMD_NOP) & ~is_read;
  // no-operation load or any finished program operation (page, fuse or lock write) empties the page buffers
  wire       nop_load = ls_rise & (act == HVPP_ACT_CMD) & (data_in == HVPP_CMD_NOP);
  wire       page_clr = nop_load | (timer_done & (st_r == HVPP_PROG));

  // pick one byte of a word by select line
  function automatic logic [7:0] hvpp_pick(input logic [15:0] w, input logic hi);
    hvpp_pick = hi ? w[15:8] : w[7:0];
  endfunction : hvpp_pick

  // fuse/lock byte chosen by the select pair
  logic [7:0] fuse_sel;
  always_comb begin
    case ({bs2, bs1})
      HVPP_SEL_FLO:  fuse_sel = fuse_lo_r;
      HVPP_SEL_FHI:  fuse_sel = fuse_hi_r;
      HVPP_SEL_FEXT: fuse_sel = fuse_ext_r;
      default:       fuse_sel = lock_r;
    endcase
  end

  // read mux for the active read command
  logic [7:0] rd_nxt;
  always_comb begin
    case (cmd_r)
      HVPP_CMD_RD_FLASH:  rd_nxt = hvpp_pick(flash_mem[faddr], bs1);
      HVPP_CMD_RD_EEPROM: rd_nxt = ee_mem[eaddr];
      HVPP_CMD_RD_FUSE:   rd_nxt = fuse_sel;
      HVPP_CMD_RD_SIG: begin
        case (addr_lo_r[1:0])
          2'h0:    rd_nxt = bs1 ? CAL0 : SIG0;
          2'h1:    rd_nxt = SIG1;
          default: rd_nxt = SIG2;
        endcase
      end
      default:            rd_nxt = 8'h00;
    endcase
  end

  // operation sequencing
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      HVPP_IDLE: begin
        if (op_start) begin
          st_nxt = (cmd_r == HVPP_CMD_ERASE) ? HVPP_ERASE : HVPP_PROG;
        end
      end
      HVPP_ERASE, HVPP_PROG: begin
        if (timer_done) begin
          st_nxt = HVPP_IDLE;
        end
      end
      default: st_nxt = HVPP_IDLE;
    endcase
  end

  hvpp_busy_timer #(.W(8)) u_timer (
    .clock (clock),
    .rst   (rst | ~prog_mode),
    .start (op_start),
    .load  (op_cycles),
    .busy  (timer_busy),
    .done  (timer_done)
  );

  // mode entry, strobe edges, loads and outputs
  always_ff @(posedge clock) begin
    if (rst | ~prog_mode) begin
      in_prog_r   <= 1'b0;
      ls_d_r      <= 1'b0;
      wr_d_r      <= 1'b1;
      pl_d_r      <= 1'b0;
      cmd_r       <= HVPP_CMD_NOP;
      addr_lo_r   <= 8'h00;
      addr_hi_r   <= 8'h00;
      dat_lo_r    <= 8'h00;
      dat_hi_r    <= 8'h00;
      page_live_r <= 1'b0;
      st_r        <= HVPP_IDLE;
      wr_cmd_r    <= HVPP_CMD_NOP;
      rd_r        <= 8'h00;
      rd_oe_n_r   <= 1'b1;
      ready_busy_n <= 1'b1;
    end else begin
      // entry pattern latched on any cycle of high voltage until programming mode is in
      if (~in_prog_r) begin
        in_prog_r <= ~act[1] & ~act[0] & ~bs1 & ~wr_n;
      end
      ls_d_r <= load_strobe;
      wr_d_r <= wr_n;
      pl_d_r <= bs1;
      st_r   <= st_nxt;
      if (op_start) begin
        wr_cmd_r <= cmd_r;
      end
      if (ls_rise) begin
        case (act)
          HVPP_ACT_ADDR: begin
            if (bs1) begin
              addr_hi_r <= data_in;
            end else begin
              addr_lo_r <= data_in;
            end
          end
          HVPP_ACT_DATA: begin
            if (bs1) begin
              dat_hi_r <= data_in;
            end else begin
              dat_lo_r <= data_in;
            end
          end
          HVPP_ACT_CMD: begin
            cmd_r <= data_in;
            if (data_in == HVPP_CMD_NOP) begin
              page_live_r <= 1'b0;
            end
          end
          default: ;                                     // idle action
        endcase
      end
      if (pl_rise & ((cmd_r == HVPP_CMD_WR_FLASH) | (cmd_r == HVPP_CMD_WR_EEPROM))) begin
        page_live_r <= 1'b1;
      end
      ready_busy_n <= ~(timer_busy | op_start);
      rd_r         <= rd_nxt;
      rd_oe_n_r    <= ~(~oe_n & is_read & in_prog_r);
    end
  end

  // page buffers: refilled with erased values so unloaded words stay blank,
  // otherwise captured on the page-load edge
  always_ff @(posedge clock) begin
    if (rst | ~prog_mode | page_clr) begin
      for (int i = 0; i < PW; i++) begin
        fpage[i] <= {HVPP_ERASED, HVPP_ERASED};
      end
      for (int i = 0; i < EP; i++) begin
        epage[i] <= HVPP_ERASED;
      end
    end else begin
      if (pl_rise & (cmd_r == HVPP_CMD_WR_FLASH)) begin
        fpage[word_in_page_bits] <= {dat_hi_r, dat_lo_r};
      end
      if (pl_rise & (cmd_r == HVPP_CMD_WR_EEPROM)) begin
        epage[ee_word] <= dat_lo_r;
      end
    end
  end

  // memory updates at the end of a self-timed operation
  always_ff @(posedge clock) begin
    if (timer_done & (st_r == HVPP_ERASE)) begin
      for (int i = 0; i < FW; i++) begin
        flash_mem[i] <= {HVPP_ERASED, HVPP_ERASED};
      end
      if (~eeprom_keep_fuse) begin
        for (int i = 0; i < EW; i++) begin
          ee_mem[i] <= HVPP_ERASED;
        end
      end
    end else if (timer_done & (st_r == HVPP_PROG)) begin
      if ((wr_cmd_r == HVPP_CMD_WR_FLASH) & page_live_r) begin  // only a loaded page
        for (int i = 0; i < PW; i++) begin
          flash_mem[{page_index_bits, PAGE_W'(i)}] <= fpage[i];
        end
      end
      if ((wr_cmd_r == HVPP_CMD_WR_EEPROM) & page_live_r) begin  // only a loaded page
        for (int i = 0; i < EP; i++) begin
          ee_mem[{eaddr[EE_AW-1:EE_PAGE_W], EE_PAGE_W'(i)}] <= epage[i];
        end
      end
    end
  end

  // fuse and lock bits; erase never touches fuses
  always_ff @(posedge clock) begin
    if (rst) begin
      fuse_lo_r  <= HVPP_FUSE_RST;
      fuse_hi_r  <= HVPP_FUSE_RST;
      fuse_ext_r <= HVPP_FUSE_RST;
      lock_r     <= HVPP_FUSE_RST;
    end else if (timer_done & (st_r == HVPP_ERASE)) begin
      lock_r <= HVPP_ERASED;
    end else if (timer_done & (st_r == HVPP_PROG)) begin
      if (wr_cmd_r == HVPP_CMD_WR_LOCK) begin
        lock_r <= lock_r & dat_lo_r;                     // only programs bits
      end
      if (wr_cmd_r == HVPP_CMD_WR_FUSE) begin
        case ({bs2, bs1})
          HVPP_SEL_LOCK: fuse_hi_r  <= dat_lo_r;
          HVPP_SEL_FEXT: fuse_ext_r <= dat_lo_r;
          default:       fuse_lo_r  <= dat_lo_r;
        endcase
      end
    end
  end

  assign data_out  = rd_r;
  assign data_oe_n = rd_oe_n_r;
  assign in_prog   = in_prog_r;
endmodule : hvpp_port

// ==== design/hvpp_pkg.sv ====
// constants for the parallel high-voltage programming port
package hvpp_pkg;
  // action-select codes on the load strobe
  localparam logic [1:0] HVPP_ACT_ADDR = 2'h0;
  localparam logic [1:0] HVPP_ACT_DATA = 2'h1;
  localparam logic [1:0] HVPP_ACT_CMD  = 2'h2;
  localparam logic [1:0] HVPP_ACT_IDLE = 2'h3;
  // command bytes
  localparam logic [7:0] HVPP_CMD_NOP       = 8'h00;
  localparam logic [7:0] HVPP_CMD_ERASE     = 8'h80;
  localparam logic [7:0] HVPP_CMD_WR_FUSE   = 8'h40;
  localparam logic [7:0] HVPP_CMD_WR_LOCK   = 8'h20;
  localparam logic [7:0] HVPP_CMD_WR_FLASH  = 8'h10;
  localparam logic [7:0] HVPP_CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] HVPP_CMD_RD_SIG    = 8'h08;
  localparam logic [7:0] HVPP_CMD_RD_FUSE   = 8'h04;
  localparam logic [7:0] HVPP_CMD_RD_FLASH  = 8'h02;
  localparam logic [7:0] HVPP_CMD_RD_EEPROM = 8'h03;
  // byte-select pair (second, first) under fuse/lock read
  localparam logic [1:0] HVPP_SEL_FLO  = 2'h0;
  localparam logic [1:0] HVPP_SEL_LOCK = 2'h1;
  localparam logic [1:0] HVPP_SEL_FEXT = 2'h2;
  localparam logic [1:0] HVPP_SEL_FHI  = 2'h3;
  // erased and reset values
  localparam logic [7:0] HVPP_ERASED   = 8'hFF;
  localparam logic [7:0] HVPP_FUSE_RST = 8'hFF;
  // bit position of the eeprom-preserve fuse in the high fuse byte
  localparam int         HVPP_KEEP_BIT = 6;
  // self-timed operation durations in clock cycles
  localparam int         HVPP_ERASE_CYC = 64;
  localparam int         HVPP_PROG_CYC  = 16;
  localparam int         HVPP_FUSE_CYC  = 8;
endpackage : hvpp_pkg

// ==== design/hvpp_busy_timer.sv ====
// one-shot busy timer: counts a load value down to zero
`timescale 1ns/10ps
module hvpp_busy_timer #(
  parameter int W = 8
) (
  input  wire logic         clock,    // system clock
  input  wire logic         rst,      // synchronous reset
  input  wire logic         start,    // pulse: load count
  input  wire logic [W-1:0] load,     // cycles to stay busy
  output logic              busy,     // high while counting
  output logic              done      // pulse: count reached zero
);
  logic [W-1:0] cnt_r;                // remaining cycles
  logic         done_r;               // end pulse

  assign busy = (cnt_r != '0);
  assign done = done_r;

  // load, then count down; pulse once at the end
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else if (start) begin
      cnt_r  <= load;
      done_r <= 1'b0;
    end else begin
      done_r <= (cnt_r == W'(1));
      if (busy) begin
        cnt_r <= cnt_r - W'(1);
      end
    end
  end
endmodule : hvpp_busy_timer

// ==== testbench/hvpp_checker.sv ====
// concurrent checks on the programming port pins
`timescale 1ns/10ps
module hvpp_checker
  import hvpp_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       prog_mode,
  input wire logic       load_strobe,
  input wire logic       action_select_lo,
  input wire logic       action_select_hi_byte_sel_two,
  input wire logic       byte_sel_one_page_load,
  input wire logic       wr_n,
  input wire logic       oe_n,
  input wire logic [7:0] data_in,
  input wire logic       data_oe_n,
  input wire logic       ready_busy_n,
  input wire logic       in_prog
);
  logic       ls_r;  // load strobe history
  logic       wr_r;  // write strobe history
  logic [7:0] cmd_r; // last command taken
  // decoded events and command classes
  wire cmd_ld = in_prog && load_strobe && !ls_r &&
                {action_select_hi_byte_sel_two, action_select_lo} == HVPP_ACT_CMD;
  wire wr_go  = in_prog && ready_busy_n && wr_r && !wr_n;
  wire is_er  = cmd_r == HVPP_CMD_ERASE;
  wire is_pg  = cmd_r inside {HVPP_CMD_WR_FLASH, HVPP_CMD_WR_EEPROM};
  wire is_fu  = cmd_r inside {HVPP_CMD_WR_FUSE, HVPP_CMD_WR_LOCK};
  wire is_rd  = cmd_r inside {HVPP_CMD_RD_SIG, HVPP_CMD_RD_FUSE,
                              HVPP_CMD_RD_FLASH, HVPP_CMD_RD_EEPROM};
  // expected bus release and entry pattern, as plain signals for history
  wire oe_exp    = oe_n || !is_rd;
  wire entry_pat = !action_select_lo && !action_select_hi_byte_sel_two &&
                   !byte_sel_one_page_load && !wr_n;
  // strobe history; command shadow cleared on exit
  always_ff @(posedge clock) begin
    ls_r <= load_strobe;
    wr_r <= wr_n;
    if (rst || !prog_mode) begin
      cmd_r <= HVPP_CMD_NOP;
    end else if (cmd_ld) begin
      cmd_r <= data_in;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_erase_busy_time:
    assert property (is_er && wr_go |=> !ready_busy_n ##62 !ready_busy_n ##[1:4] ready_busy_n)
    else $error("erase busy span wrong");
  a_page_busy_time:
    assert property (is_pg && wr_go |=> !ready_busy_n ##14 !ready_busy_n ##[1:4] ready_busy_n)
    else $error("page program busy span wrong");
  a_fuse_busy_time:
    assert property (is_fu && wr_go |=> (!ready_busy_n)[*8] ##[1:4] ready_busy_n)
    else $error("fuse or lock busy span wrong");
  a_busy_has_cause:
    assert property ($fell(ready_busy_n) |-> $past(wr_go)) else $error("busy without write");
  a_idle_cmd_refused:
    assert property (wr_go && !(is_er || is_pg || is_fu) |=> ready_busy_n[*2])
    else $error("write ran without write command");
  a_bus_enable:
    assert property (data_oe_n == $past(oe_exp)) else $error("bus enable wrong");
  a_entry_pattern:
    assert property ($rose(in_prog) |-> $past(entry_pat)) else $error("bad entry");
  a_exit_clears:
    assert property (!prog_mode |=> !in_prog && data_oe_n) else $error("mode not left");
endmodule : hvpp_checker
bind hvpp_port hvpp_checker u_chk (.clock(clock), .rst(rst), .prog_mode(prog_mode),
  .load_strobe(load_strobe), .action_select_lo(action_select_lo),
  .action_select_hi_byte_sel_two(action_select_hi_byte_sel_two),
  .byte_sel_one_page_load(byte_sel_one_page_load), .wr_n(wr_n), .oe_n(oe_n),
  .data_in(data_in), .data_oe_n(data_oe_n), .ready_busy_n(ready_busy_n), .in_prog(in_prog));

// ==== testbench/hvpp_programmer.sv ====
// behavioural high-voltage programmer facing the port
`timescale 1ns/10ps
module hvpp_programmer (
  input  wire logic       clock,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n,
  input  wire logic       ready_busy_n,
  output logic            prog_mode,
  output logic            load_strobe,
  output logic            act_lo,
  output logic            act_hi,
  output logic            bs1,
  output logic            wr_n,
  output logic            oe_n,
  output wire logic [7:0] bus
);
  localparam int PW = 25; // minimum pulse width in cycles
  logic [7:0] drv_r;      // byte put out by the programmer
  // floating bus shows the inverse of our last byte
  assign bus = !data_oe_n ? data_out : (oe_n ? drv_r : ~drv_r);
  // high voltage on, entry pattern all zero
  initial begin
    {prog_mode, wr_n, oe_n, load_strobe, act_lo, act_hi, bs1} = 7'h50;
    drv_r = 8'h00;
  end
  // entry latched: write strobe back to idle
  task automatic entry_done();
    wr_n <= 1'b1;
  endtask : entry_done
  // high voltage off: leave programming mode
  task automatic leave();
    prog_mode <= 1'b0;
  endtask : leave
  // one load: action code, select one, byte, then a long strobe
  task automatic load(input logic [1:0] act, input logic b1, input logic [7:0] v);
    @(posedge clock);
    {act_hi, act_lo} <= act;
    bs1 <= b1;
    drv_r <= v;
    @(posedge clock);
    load_strobe <= 1'b1;
    repeat (PW) @(posedge clock);
    load_strobe <= 1'b0;
  endtask : load
  // page load pulse on select one
  task automatic page();
    bs1 <= 1'b0;
    @(posedge clock);
    bs1 <= 1'b1;
    repeat (PW) @(posedge clock);
    bs1 <= 1'b0;
  endtask : page
  // write pulse, then bounded wait for ready
  task automatic wr(input logic b2, input logic b1);
    @(posedge clock);
    {act_hi, bs1} <= {b2, b1};
    @(posedge clock);
    wr_n <= 1'b0;
    repeat (PW) @(posedge clock);
    wr_n <= 1'b1;
    for (int n = 0; n < 200 && ready_busy_n !== 1'b1; n++) @(posedge clock);
    @(posedge clock);
    {act_hi, bs1} <= 2'h0;
  endtask : wr
  // read one byte with output enable low
  task automatic rd(input logic b2, input logic b1, output logic [7:0] v);
    @(posedge clock);
    {act_hi, bs1, oe_n} <= {b2, b1, 1'b0};
    repeat (3) @(posedge clock);
    @(negedge clock);
    v = bus;
    @(posedge clock);
    oe_n <= 1'b1;
  endtask : rd
endmodule : hvpp_programmer

// ==== testbench/testbench.sv ====
// self-checking bench for the programming port
`timescale 1ns/10ps
module testbench
  import hvpp_pkg::*;
;
  localparam logic [7:0] SIGS [4] = '{8'hA5, 8'h3C, 8'h69, 8'h4B}; // arbitrary values
  localparam logic [7:0] FUSE_EXP [4] = '{8'hFF, 8'hFC, 8'hFF, 8'hBF}; // by select pair
  logic       clock = 1'b0; // 100 MHz clock
  logic       rst   = 1'b1; // held ten cycles
  int         n_fail = 0;   // mismatches
  int         n_checks = 0; // comparisons
  wire  [7:0] data_out, bus;
  wire        data_oe_n, ready_busy_n, in_prog, prog_mode, load_strobe;
  wire        act_lo, act_hi, bs1, wr_n, oe_n;
  hvpp_port #(.SIG0(SIGS[0]), .SIG1(SIGS[1]), .SIG2(SIGS[2]), .CAL0(SIGS[3])) u_dut (
    .clock(clock), .rst(rst), .prog_mode(prog_mode), .load_strobe(load_strobe),
    .action_select_lo(act_lo), .action_select_hi_byte_sel_two(act_hi),
    .byte_sel_one_page_load(bs1), .wr_n(wr_n), .oe_n(oe_n), .data_in(bus),
    .data_out(data_out), .data_oe_n(data_oe_n), .ready_busy_n(ready_busy_n), .in_prog(in_prog));
  hvpp_programmer u_prog (.clock(clock), .data_out(data_out), .data_oe_n(data_oe_n),
    .ready_busy_n(ready_busy_n), .prog_mode(prog_mode), .load_strobe(load_strobe),
    .act_lo(act_lo), .act_hi(act_hi), .bs1(bs1), .wr_n(wr_n), .oe_n(oe_n), .bus(bus));
  always #5 clock = ~clock;
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // read through the port and compare
  task automatic er(input logic b2, input logic b1, input logic [7:0] exp);
    logic [7:0] v;
    u_prog.rd(b2, b1, v);
    chk(v, exp);
  endtask : er
  // write pulse through the port; ready must stand once it returns
  task automatic go(input logic b2, input logic b1);
    u_prog.wr(b2, b1);
    chk({7'h00, ready_busy_n}, 8'h01);
  endtask : go
  // command and low address loads
  task automatic cmd(input logic [7:0] c);
    u_prog.load(HVPP_ACT_CMD, 1'b0, c);
  endtask : cmd
  task automatic adr(input logic [7:0] a);
    u_prog.load(HVPP_ACT_ADDR, 1'b0, a);
  endtask : adr
  // verdict and end of run
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    repeat (1000) @(posedge clock);
    chk({7'h00, in_prog}, 8'h01);
    u_prog.entry_done();
    repeat (30000) @(posedge clock);
    $display("entry test done");
    cmd(HVPP_CMD_ERASE);
    go(1'b0, 1'b0);
    cmd(HVPP_CMD_WR_FLASH);
    u_prog.load(HVPP_ACT_ADDR, 1'b1, 8'h00);
    for (int i = 0; i < 2; i++) begin
      adr(8'(i));
      u_prog.load(HVPP_ACT_DATA, 1'b0, 8'(8'h30 + i));
      u_prog.load(HVPP_ACT_DATA, 1'b1, 8'(8'hC0 + i));
      u_prog.page();
    end
    go(1'b0, 1'b0);
    cmd(HVPP_CMD_NOP);
    go(1'b0, 1'b0);
    cmd(HVPP_CMD_RD_FLASH);
    for (int i = 0; i < 3; i++) begin
      adr(i < 2 ? 8'(i) : 8'h40);
      er(1'b0, 1'b0, i < 2 ? 8'(8'h30 + i) : HVPP_ERASED);
      er(1'b0, 1'b1, i < 2 ? 8'(8'hC0 + i) : HVPP_ERASED);
    end
    $display("flash test done");
    cmd(HVPP_CMD_WR_EEPROM);
    adr(8'h05);
    u_prog.load(HVPP_ACT_DATA, 1'b0, 8'h5A);
    u_prog.page();
    go(1'b0, 1'b0);
    cmd(HVPP_CMD_RD_EEPROM);
    er(1'b0, 1'b0, 8'h5A);
    adr(8'h10);
    er(1'b0, 1'b0, HVPP_ERASED);
    $display("eeprom test done");
    cmd(HVPP_CMD_WR_FUSE);
    u_prog.load(HVPP_ACT_DATA, 1'b0, 8'hBF);
    go(1'b0, 1'b1);
    cmd(HVPP_CMD_WR_LOCK);
    u_prog.load(HVPP_ACT_DATA, 1'b0, 8'hFC);
    go(1'b0, 1'b0);
    cmd(HVPP_CMD_RD_FUSE);
    for (int i = 0; i < 4; i++) er(i[1], i[0], FUSE_EXP[i]);
    $display("fuse test done");
    cmd(HVPP_CMD_ERASE);
    go(1'b0, 1'b0);
    cmd(HVPP_CMD_RD_FUSE);
    er(1'b0, 1'b1, HVPP_ERASED);
    er(1'b1, 1'b1, 8'hBF);
    cmd(HVPP_CMD_RD_EEPROM);
    adr(8'h05);
    er(1'b0, 1'b0, 8'h5A);
    cmd(HVPP_CMD_RD_FLASH);
    adr(8'h00);
    er(1'b0, 1'b0, HVPP_ERASED);
    $display("erase test done");
    cmd(HVPP_CMD_RD_SIG);
    for (int i = 0; i < 4; i++) begin
      adr(8'(i % 3));
      er(1'b0, i == 3, SIGS[i]);
    end
    u_prog.leave();
    repeat (3) @(posedge clock);
    chk({7'h00, in_prog}, 8'h00);
    $display("signature and exit test done");
    test_done();
  end
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end
endmodule : testbench
